// File: hdl/can_btl_pkg.sv
// Constants for the CAN bit timing and synchronisation block.
// Assumes an 8-bit register port with byte addresses and one oscillator clock.
package can_btl_pkg;

    // Register addresses
    localparam logic [7:0] ADDR_CONFIG_THREE = 8'h28;
    localparam logic [7:0] ADDR_CONFIG_TWO   = 8'h29;
    localparam logic [7:0] ADDR_CONFIG_ONE   = 8'h2a;

    // Reset values
    localparam logic [7:0] RST_CONFIG_ONE   = 8'h00;
    localparam logic [7:0] RST_CONFIG_TWO   = 8'h00;
    localparam logic [7:0] RST_CONFIG_THREE = 8'h00;

    // Writable bits of the third register; the rest read zero
    localparam logic [7:0] CONFIG_THREE_MASK = 8'h47;

    // Field layout of bit_timing_config_one
    localparam int PRESC_LSB = 0;
    localparam int PRESC_W   = 6;
    localparam int JUMP_LSB  = 6;
    localparam int JUMP_W    = 2;

    // Field layout of bit_timing_config_two
    localparam int PROP_LSB     = 0;
    localparam int PHASE1_LSB   = 3;
    localparam int TRIPLE_BIT   = 6;
    localparam int PH2_SRC_BIT  = 7;
    localparam int SEG_FIELD_W  = 3;

    // Field layout of bit_timing_config_three
    localparam int PHASE2_LSB = 0;
    localparam int WAKE_BIT   = 6;

    // Quantum counts; wide enough for a lengthened phase segment 1
    localparam int          TQ_W       = 5;
    localparam logic [4:0]  SYNC_TQ    = 5'h01;
    localparam logic [4:0]  IPT_TQ     = 5'h02;

    // Recessive bus level
    localparam logic        RECESSIVE  = 1'b1;

    typedef enum logic [1:0] {
        SEG_SYNC,
        SEG_PROP,
        SEG_PHASE1,
        SEG_PHASE2
    } seg_t;

endpackage

// File: hdl/can_btl_cfg_if.sv
// Configuration fields passed from the register file to the timing core.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface can_btl_cfg_if;
    import can_btl_pkg::*;

    logic [PRESC_W-1:0]     quantum_prescaler;
    logic [JUMP_W-1:0]      jump_width_field;
    logic                   triple_sample_sel;
    logic                   phase2_source_sel;
    logic [SEG_FIELD_W-1:0] phase1_len_field;
    logic [SEG_FIELD_W-1:0] prop_len_field;
    logic [SEG_FIELD_W-1:0] phase2_len_field;
    logic                   wake_filter_en;

    modport regs (
        output quantum_prescaler,
        output jump_width_field,
        output triple_sample_sel,
        output phase2_source_sel,
        output phase1_len_field,
        output prop_len_field,
        output phase2_len_field,
        output wake_filter_en
    );

    modport core (
        input  quantum_prescaler,
        input  jump_width_field,
        input  triple_sample_sel,
        input  phase2_source_sel,
        input  phase1_len_field,
        input  prop_len_field,
        input  phase2_len_field,
        input  wake_filter_en
    );
endinterface

// File: hdl/can_btl_regs.sv
// Three bit timing configuration registers with a registered read port.
// Assumes config_mode_i comes from mode control on the same clock.
`timescale 1ns/10ps
module can_btl_regs (
    // Clock and reset
    input  wire logic       clock_i,
    input  wire logic       sys_rst_i,
    // Register port
    input  wire logic [7:0] reg_addr_i,
    input  wire logic       reg_wr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       config_mode_i,
    output logic      [7:0] reg_rdata_o,
    // Fields to the core
    can_btl_cfg_if.regs     cfg
);
    import can_btl_pkg::*;

    logic [7:0] config_one_q;
    logic [7:0] config_two_q;
    logic [7:0] config_three_q;

    // Writes outside configuration mode are dropped silently
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            config_one_q   <= RST_CONFIG_ONE;
            config_two_q   <= RST_CONFIG_TWO;
            config_three_q <= RST_CONFIG_THREE;
        end else if (reg_wr_i && config_mode_i) begin
            if (reg_addr_i == ADDR_CONFIG_ONE) begin
                config_one_q <= reg_wdata_i;
            end
            if (reg_addr_i == ADDR_CONFIG_TWO) begin
                config_two_q <= reg_wdata_i;
            end
            if (reg_addr_i == ADDR_CONFIG_THREE) begin
                config_three_q <= reg_wdata_i & CONFIG_THREE_MASK;
            end
        end
    end

    // Unmapped addresses read zero
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            unique case (reg_addr_i)
                ADDR_CONFIG_ONE:   reg_rdata_o <= config_one_q;
                ADDR_CONFIG_TWO:   reg_rdata_o <= config_two_q;
                ADDR_CONFIG_THREE: reg_rdata_o <= config_three_q;
                default:           reg_rdata_o <= 8'h00;
            endcase
        end
    end

    assign cfg.quantum_prescaler = config_one_q[PRESC_LSB +: PRESC_W];
    assign cfg.jump_width_field  = config_one_q[JUMP_LSB +: JUMP_W];
    assign cfg.prop_len_field    = config_two_q[PROP_LSB +: SEG_FIELD_W];
    assign cfg.phase1_len_field  = config_two_q[PHASE1_LSB +: SEG_FIELD_W];
    assign cfg.triple_sample_sel = config_two_q[TRIPLE_BIT];
    assign cfg.phase2_source_sel = config_two_q[PH2_SRC_BIT];
    assign cfg.phase2_len_field  = config_three_q[PHASE2_LSB +: SEG_FIELD_W];
    assign cfg.wake_filter_en    = config_three_q[WAKE_BIT];

endmodule

// File: hdl/can_bit_timing_sync.sv
// CAN bit timing and synchronisation: quantum prescaler, bit segment
// sequencer, hard sync and resync with jump width limit, single or
// triple sampling of the receive pin.
// Assumes bus_idle_i and tx_dominant_i come from protocol logic on clock_i,
// and the receive pin is asynchronous.
`timescale 1ns/10ps
module can_bit_timing_sync #(
    parameter int PRESC_WIDTH = can_btl_pkg::PRESC_W
) (
    // Clock and reset
    input  wire logic       clock_i,
    input  wire logic       sys_rst_i,
    // Register port
    input  wire logic [7:0] reg_addr_i,
    input  wire logic       reg_wr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       config_mode_i,
    output logic      [7:0] reg_rdata_o,
    // Bus side
    input  wire logic       bus_receive_pin_i,
    input  wire logic       bus_idle_i,
    input  wire logic       tx_dominant_i,
    // Timing outputs
    output logic            sample_strobe_o,
    output logic            rx_bit_o,
    output logic            bit_start_o,
    output logic            hard_sync_o,
    output logic            resync_o,
    output logic            wake_filter_en_o
);
    import can_btl_pkg::*;

    // The prescaler field is fixed by the register layout
    if (PRESC_WIDTH != PRESC_W) begin : g_presc_check
        $error("PRESC_WIDTH must match the prescaler field width");
    end

    can_btl_cfg_if cfg ();

    can_btl_regs u_regs (
        .clock_i       (clock_i),
        .sys_rst_i     (sys_rst_i),
        .reg_addr_i    (reg_addr_i),
        .reg_wr_i      (reg_wr_i),
        .reg_wdata_i   (reg_wdata_i),
        .config_mode_i (config_mode_i),
        .reg_rdata_o   (reg_rdata_o),
        .cfg           (cfg.regs)
    );

    // Field value plus one, at quantum counter width
    function automatic logic [TQ_W-1:0] seg_len(input logic [SEG_FIELD_W-1:0] field);
        seg_len = TQ_W'({2'b00, field}) + TQ_W'(1);
    endfunction

    // Majority of three
    function automatic logic majority(input logic a, input logic b, input logic c);
        majority = (a & b) | (a & c) | (b & c);
    endfunction

    // Receive pin synchroniser and edge history
    logic rx_meta_q;
    logic rx_sync_q;
    logic rx_prev_q;

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            rx_meta_q <= RECESSIVE;
            rx_sync_q <= RECESSIVE;
        end else begin
            rx_meta_q <= bus_receive_pin_i;
            rx_sync_q <= rx_meta_q;
        end
    end

    // Recessive after reset, so no false edge follows reset
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            rx_prev_q <= RECESSIVE;
        end else begin
            rx_prev_q <= rx_sync_q;
        end
    end

    // Segment lengths from the configuration
    logic [TQ_W-1:0] prop_len;
    logic [TQ_W-1:0] phase1_len;
    logic [TQ_W-1:0] phase2_len;
    logic [TQ_W-1:0] jump_len;

    always_comb begin
        prop_len   = seg_len(cfg.prop_len_field);
        phase1_len = seg_len(cfg.phase1_len_field);
        jump_len   = TQ_W'(cfg.jump_width_field) + TQ_W'(1);
        if (cfg.phase2_source_sel) begin
            phase2_len = seg_len(cfg.phase2_len_field);
        end else if (phase1_len > IPT_TQ) begin
            phase2_len = phase1_len;
        end else begin
            phase2_len = IPT_TQ;
        end
    end

    // Prescaler: half-quantum ticks, so triple sampling can use them.
    // A smaller prescaler written mid-count wraps once; writes only
    // happen in configuration mode, so one odd quantum is accepted.
    logic [PRESC_WIDTH-1:0] presc_q;
    logic                   half_q;
    logic                   half_tick;
    logic                   tq_tick;
    logic                   restart;

    assign half_tick = (presc_q == cfg.quantum_prescaler);
    assign tq_tick   = half_tick & half_q;

    always_ff @(posedge clock_i) begin
        if (sys_rst_i || restart) begin
            presc_q <= '0;
            half_q  <= 1'b0;
        end else if (half_tick) begin
            presc_q <= '0;
            half_q  <= ~half_q;
        end else begin
            presc_q <= presc_q + PRESC_WIDTH'(1);
        end
    end

    // Segment sequencer state
    seg_t            seg_q;
    logic [TQ_W-1:0] tq_cnt_q;
    logic [TQ_W-1:0] phase1_ext_q;
    logic [TQ_W-1:0] phase2_end_q;
    logic            synced_q;
    logic            sampled_q;
    logic [1:0]      hist_q;

    // Synchronisation decisions
    logic            fall_edge;
    logic            edge_usable;
    logic            hard_ev;
    logic            resync_ev;
    logic            sync_ev;
    logic            lengthen;
    logic            shorten;
    logic [TQ_W-1:0] pos_err;
    logic [TQ_W-1:0] neg_err;
    logic [TQ_W-1:0] phase1_total;
    logic            phase1_end;
    logic            phase2_end;
    logic            seg_end;
    logic            sample_val;

    assign phase1_total = phase1_len + phase1_ext_q;

    always_comb begin
        fall_edge   = (rx_prev_q == RECESSIVE) && (rx_sync_q != RECESSIVE);
        edge_usable = fall_edge && (sampled_q != rx_sync_q) && !synced_q;
        hard_ev     = 1'b0;
        resync_ev   = 1'b0;
        lengthen    = 1'b0;
        shorten     = 1'b0;
        pos_err     = '0;
        neg_err     = '0;
        if (seg_q == SEG_PROP) begin
            pos_err = tq_cnt_q + TQ_W'(1);
        end else if (seg_q == SEG_PHASE1) begin
            pos_err = prop_len + tq_cnt_q + TQ_W'(1);
        end
        if (seg_q == SEG_PHASE2) begin
            neg_err = phase2_end_q - tq_cnt_q;
        end
        if (fall_edge && bus_idle_i && !synced_q) begin
            hard_ev = 1'b1;
        end else if (edge_usable && !bus_idle_i) begin
            unique case (seg_q)
                SEG_SYNC: begin
                    // Zero error: nothing to correct, but the bit is spent
                    resync_ev = 1'b1;
                end
                SEG_PROP, SEG_PHASE1: begin
                    if (!tx_dominant_i) begin
                        resync_ev = 1'b1;
                        lengthen  = (pos_err > jump_len);
                    end
                end
                SEG_PHASE2: begin
                    resync_ev = 1'b1;
                    shorten   = (neg_err > jump_len);
                end
            endcase
        end
        sync_ev = hard_ev | resync_ev;
        // Small error restarts the bit exactly like a hard sync
        restart = hard_ev | (resync_ev && (seg_q != SEG_SYNC)
                  && !lengthen && !shorten);
    end

    always_comb begin
        phase1_end = (seg_q == SEG_PHASE1) && (tq_cnt_q == phase1_total - TQ_W'(1))
                     && !lengthen;
        phase2_end = (seg_q == SEG_PHASE2) && (tq_cnt_q == phase2_end_q - TQ_W'(1));
        unique case (seg_q)
            SEG_SYNC:   seg_end = (tq_cnt_q == SYNC_TQ - TQ_W'(1));
            SEG_PROP:   seg_end = (tq_cnt_q == prop_len - TQ_W'(1));
            SEG_PHASE1: seg_end = phase1_end;
            SEG_PHASE2: seg_end = phase2_end;
        endcase
    end

    // Segment sequencing
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            seg_q    <= SEG_SYNC;
            tq_cnt_q <= '0;
        end else if (restart) begin
            seg_q    <= SEG_SYNC;
            tq_cnt_q <= '0;
        end else if (tq_tick) begin
            if (seg_end) begin
                tq_cnt_q <= '0;
                unique case (seg_q)
                    SEG_SYNC:   seg_q <= SEG_PROP;
                    SEG_PROP:   seg_q <= SEG_PHASE1;
                    SEG_PHASE1: seg_q <= SEG_PHASE2;
                    SEG_PHASE2: seg_q <= SEG_SYNC;
                endcase
            end else begin
                tq_cnt_q <= tq_cnt_q + TQ_W'(1);
            end
        end
    end

    // Phase segment 1 extension, held until the sample point
    always_ff @(posedge clock_i) begin
        if (sys_rst_i || restart) begin
            phase1_ext_q <= '0;
        end else if (lengthen) begin
            phase1_ext_q <= jump_len;
        end else if (tq_tick && phase1_end) begin
            phase1_ext_q <= '0;
        end
    end

    // Phase segment 2 length, latched at the sample point
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            phase2_end_q <= IPT_TQ;
        end else if (shorten) begin
            phase2_end_q <= phase2_end_q - jump_len;
        end else if (tq_tick && phase1_end) begin
            phase2_end_q <= phase2_len;
        end
    end

    // One sync per bit; a new sync wins over the clear at bit start
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            synced_q <= 1'b0;
        end else if (sync_ev) begin
            synced_q <= 1'b1;
        end else if (tq_tick && phase2_end) begin
            synced_q <= 1'b0;
        end
    end

    // History at half-quantum spacing for the majority vote
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            hist_q <= {RECESSIVE, RECESSIVE};
        end else if (half_tick) begin
            hist_q <= {hist_q[0], rx_sync_q};
        end
    end

    assign sample_val = cfg.triple_sample_sel ? majority(hist_q[1], hist_q[0], rx_sync_q)
                                              : rx_sync_q;

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            sampled_q <= RECESSIVE;
        end else if (tq_tick && phase1_end && !restart) begin
            sampled_q <= sample_val;
        end
    end

    // Sample point outputs
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            sample_strobe_o  <= 1'b0;
            rx_bit_o         <= RECESSIVE;
        end else begin
            sample_strobe_o  <= tq_tick && phase1_end && !restart;
            rx_bit_o         <= sampled_q;
        end
    end

    // Synchronisation pulses
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            bit_start_o      <= 1'b0;
            hard_sync_o      <= 1'b0;
            resync_o         <= 1'b0;
        end else begin
            bit_start_o      <= restart || (tq_tick && phase2_end);
            hard_sync_o      <= hard_ev;
            resync_o         <= resync_ev;
        end
    end

    // Configuration copy
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            wake_filter_en_o <= 1'b0;
        end else begin
            wake_filter_en_o <= cfg.wake_filter_en;
        end
    end

    // Software is trusted to keep segment lengths consistent; not checked
    // here, a bad setting just gives a mistimed bit.

endmodule

// File: bench/can_bit_timing_sync_props.sv
// Checker for the bit timing block; watches the top-level ports only.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/10ps
module can_bit_timing_sync_props (
    // Clock and reset
    input wire logic       clock_i,
    input wire logic       sys_rst_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic       reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       config_mode_i,
    input wire logic [7:0] reg_rdata_o,
    // Bus side and timing
    input wire logic       bus_idle_i,
    input wire logic       sample_strobe_o,
    input wire logic       rx_bit_o,
    input wire logic       bit_start_o,
    input wire logic       hard_sync_o,
    input wire logic       resync_o,
    input wire logic       wake_filter_en_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    logic [1:0] sync_cnt_q;

    // Counts sync events since the last bit start; saturates so a burst stays visible
    always_ff @(posedge clock_i) begin
        if (sys_rst_i || bit_start_o) begin
            sync_cnt_q <= {1'h0, hard_sync_o | resync_o};
        end else if ((hard_sync_o || resync_o) && sync_cnt_q != 2'h3) begin
            sync_cnt_q <= sync_cnt_q + 2'h1;
        end
    end

    sequence s_quiet_strobe;
        !sample_strobe_o [*3];
    endsequence

    sequence s_single_start;
        bit_start_o ##1 !bit_start_o;
    endsequence

    a_hard_idle_only: assert property (hard_sync_o |-> $past(bus_idle_i))
        else $error("hard sync outside bus idle");
    a_resync_busy_only: assert property (resync_o |-> !$past(bus_idle_i))
        else $error("resync during bus idle");
    a_hard_restarts_bit: assert property (hard_sync_o |-> s_single_start)
        else $error("hard sync without bit restart");
    a_one_sync_bit: assert property (sync_cnt_q <= 2'h1)
        else $error("second sync in one bit");
    a_strobe_pulse_gap: assert property (sample_strobe_o |=> s_quiet_strobe)
        else $error("sample strobe too close");
    a_sync_seg_quiet: assert property (bit_start_o |=> !sample_strobe_o [*4])
        else $error("strobe inside sync segment");
    a_rx_on_strobe: assert property ($changed(rx_bit_o) |->
        (sample_strobe_o || $past(sample_strobe_o) || $past(sample_strobe_o, 2)))
        else $error("received bit moved off sample point");
    a_wake_copy_bit: assert property (reg_wr_i && config_mode_i && reg_addr_i == 8'h28
        |-> ##2 wake_filter_en_o == $past(reg_wdata_i[6], 2))
        else $error("wake filter enable not copied");
    a_cfg_write_locked: assert property (reg_wr_i && !config_mode_i
        |=> ##1 $stable(wake_filter_en_o))
        else $error("write taken outside configuration mode");
    a_cfg3_unused_zero: assert property (reg_addr_i == 8'h28
        |=> (reg_rdata_o & 8'hb8) == 8'h00)
        else $error("unused bits of third register not zero");
endmodule

bind can_bit_timing_sync can_bit_timing_sync_props chk_u (.clock_i, .sys_rst_i, .reg_addr_i,
    .reg_wr_i, .reg_wdata_i, .config_mode_i, .reg_rdata_o, .bus_idle_i, .sample_strobe_o,
    .rx_bit_o, .bit_start_o, .hard_sync_o, .resync_o, .wake_filter_en_o);

// File: bench/can_bus_partner.sv
// Far-side bus node model: drives the receive line as the bus would.
// Assumes the bench requests levels; the line moves only on clock edges.
`timescale 1ns/10ps
module can_bus_partner (
    // Clock
    input  wire logic clock_i,
    // Requested level, 1 = recessive
    input  wire logic level_req_i,
    // Line seen by the receiver
    output logic      bus_line_o
);
    always_ff @(posedge clock_i) begin
        bus_line_o <= level_req_i;
    end
endmodule

// File: bench/can_bit_timing_sync_test.sv
// Self-checking bench for the bit timing block with a bus partner model.
// Assumes package, interface and design files are compiled first.
`timescale 1ns/10ps
module can_bit_timing_sync_test;
    import can_btl_pkg::*;
    logic        clock_i;
    logic        sys_rst_i;
    logic [7:0]  reg_addr_i;
    logic        reg_wr_i;
    logic [7:0]  reg_wdata_i;
    logic        config_mode_i;
    logic [7:0]  reg_rdata_o;
    logic        level_req;
    logic        bus_line;
    logic        bus_idle_i;
    logic        tx_dominant_i;
    logic        sample_strobe_o;
    logic        rx_bit_o;
    logic        bit_start_o;
    logic        hard_sync_o;
    logic        resync_o;
    logic        wake_filter_en_o;
    int          error_cnt;
    int          cmp_count;
    int          len;
    logic [31:0] rng_q;
    logic [7:0]  c1;
    logic [7:0]  c2;
    logic [7:0]  c3;
    logic [7:0]  rd;

    can_bit_timing_sync dut_u (.clock_i, .sys_rst_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i,
        .config_mode_i, .reg_rdata_o, .bus_receive_pin_i(bus_line), .bus_idle_i,
        .tx_dominant_i, .sample_strobe_o, .rx_bit_o, .bit_start_o, .hard_sync_o, .resync_o,
        .wake_filter_en_o);
    can_bus_partner partner_u (.clock_i, .level_req_i(level_req), .bus_line_o(bus_line));

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic int bit_clks(input logic [7:0] a, input logic [7:0] b,
                                    input logic [7:0] c);
        int ph1;
        int ph2;
        ph1 = int'(b[5:3]) + 1;
        ph2 = b[7] ? int'(c[2:0]) + 1 : (ph1 > 2 ? ph1 : 2);
        return 2 * (int'(a[5:0]) + 1) * (2 + int'(b[2:0]) + ph1 + ph2);
    endfunction

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'h1;
        @(posedge clock_i);
        reg_wr_i    <= 1'h0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_i);
        reg_addr_i <= a;
        repeat (2) @(posedge clock_i);
        #1;
        d = reg_rdata_o;
    endtask

    task automatic wait_sig(input bit hard);
        for (int k = 0; k < 1000; k++) begin
            @(posedge clock_i);
            #1;
            if ((hard ? hard_sync_o : bit_start_o) === 1'h1) return;
        end
        error_cnt++;
        $display("BAD t=%0t expected pulse missing", $time);
        test_done;
    endtask

    // Counts one bit; the bus level may be moved at two offsets inside it
    task automatic bit_len(input bit wait_first, input int o1, input logic l1, input int o2,
                           input logic l2, output int n);
        if (wait_first) wait_sig(1'b0);
        n = 0;
        do begin
            if (n == o1) level_req = l1;
            if (n == o2) level_req = l2;
            @(posedge clock_i);
            #1;
            n++;
        end while (bit_start_o !== 1'h1 && n < 1000);
    endtask

    initial begin
        clock_i = 1'h0;
        forever #50 clock_i = ~clock_i;
    end

    initial begin
        error_cnt = 0;
        cmp_count = 0;
        rng_q = 32'h0000_0063;
        sys_rst_i = 1'h1;
        reg_addr_i = 8'h00;
        reg_wr_i = 1'h0;
        reg_wdata_i = 8'h00;
        config_mode_i = 1'h1;
        level_req = 1'h1;
        bus_idle_i = 1'h1;
        tx_dominant_i = 1'h0;
        repeat (4) @(posedge clock_i);
        sys_rst_i <= 1'h0;
        for (int a = 39; a < 43; a++) begin
            rd_reg(8'(a), rd);
            check(rd, 8'h00);
        end
        @(posedge clock_i) bus_idle_i <= 1'h0;
        for (int i = 0; i < 6; i++) begin
            rng_q = xorshift(rng_q);
            c1 = {rng_q[7:6], 4'h0, rng_q[1:0]};
            c2 = rng_q[15:8];
            c3 = rng_q[23:16] | 8'h01;
            if (i == 0) {c1, c2, c3} = {8'h00, 8'h00, 8'h07};
            if (i == 1) {c1, c2, c3} = {8'h3f, 8'h80, 8'h01};
            wr_reg(8'h2a, c1);
            wr_reg(8'h29, c2);
            wr_reg(8'h28, c3);
            rd_reg(8'h28, rd);
            check(rd, c3 & CONFIG_THREE_MASK);
            check(wake_filter_en_o, c3[6]);
            @(posedge clock_i) config_mode_i <= 1'h0;
            wr_reg(8'h2a, ~c1);
            @(posedge clock_i) config_mode_i <= 1'h1;
            rd_reg(8'h2a, rd);
            check(rd, c1);
            bit_len(1'b1, -1, 1'h1, -1, 1'h1, len);
            bit_len(1'b1, -1, 1'h1, -1, 1'h1, len);
            check(len, bit_clks(c1, c2, c3));
        end
        wr_reg(8'h29, 8'hbf);
        wr_reg(8'h28, 8'h07);
        for (int j = 0; j < 4; j++) begin
            wr_reg(8'h2a, {2'(j), 6'h00});
            bit_len(1'b1, -1, 1'h1, -1, 1'h1, len);
            bit_len(1'b1, 10, 1'h0, -1, 1'h0, len);
            check(len, 50 + 2 * (j + 1));
            check(rx_bit_o, 1'h0);
            bit_len(1'b0, 2, 1'h1, 10, 1'h0, len);
            check(len, 50);
            bit_len(1'b0, 10, 1'h1, -1, 1'h1, len);
            check(len, 50);
        end
        wr_reg(8'h2a, 8'h00);
        bit_len(1'b1, -1, 1'h1, -1, 1'h1, len);
        bit_len(1'b1, 37, 1'h0, -1, 1'h0, len);
        check(len, 48);
        bit_len(1'b0, 10, 1'h1, -1, 1'h1, len);
        @(posedge clock_i) tx_dominant_i <= 1'h1;
        bit_len(1'b1, 10, 1'h0, -1, 1'h0, len);
        check(len, 50);
        @(posedge clock_i) tx_dominant_i <= 1'h0;
        bit_len(1'b0, 10, 1'h1, -1, 1'h1, len);
        wr_reg(8'h2a, 8'hc0);
        bit_len(1'b1, -1, 1'h1, -1, 1'h1, len);
        bit_len(1'b1, 42, 1'h0, -1, 1'h0, len);
        check(len > 42 && len < 49, 1'h1);
        bit_len(1'b0, 10, 1'h1, -1, 1'h1, len);
        @(posedge clock_i) bus_idle_i <= 1'h1;
        wait_sig(1'b0);
        level_req <= 1'h0;
        wait_sig(1'b1);
        check(bit_start_o, 1'h1);
        bit_len(1'b0, -1, 1'h0, -1, 1'h0, len);
        check(len, 50);
        test_done;
    end
endmodule
